// *** core/intc_pkg.sv ***
package intc_pkg;

    localparam int          NSRC     = 32;
    localparam int          STK      = 8;
    localparam int          AW       = 9;

    // byte offsets on the register bus
    localparam logic [8:0]  OFF_MODE  = 9'h000;
    localparam logic [8:0]  OFF_HVEC  = 9'h080;
    localparam logic [8:0]  OFF_NVEC  = 9'h100;
    localparam logic [8:0]  OFF_FVEC  = 9'h104;
    localparam logic [8:0]  OFF_CUR   = 9'h108;
    localparam logic [8:0]  OFF_PEND  = 9'h10c;
    localparam logic [8:0]  OFF_MASK  = 9'h110;
    localparam logic [8:0]  OFF_CORE  = 9'h114;
    localparam logic [8:0]  OFF_EN    = 9'h120;
    localparam logic [8:0]  OFF_DIS   = 9'h124;
    localparam logic [8:0]  OFF_CLR   = 9'h128;
    localparam logic [8:0]  OFF_SET   = 9'h12c;
    localparam logic [8:0]  OFF_EOS   = 9'h130;
    localparam logic [8:0]  OFF_GMASK = 9'h134;
    localparam logic [8:0]  OFF_SPUR  = 9'h138;
    localparam logic [8:0]  OFF_FFEN  = 9'h140;
    localparam logic [8:0]  OFF_FFDIS = 9'h144;
    localparam logic [8:0]  OFF_FFST  = 9'h148;

    // source mode register layout
    localparam int          MODE_PRIO_LSB = 0;
    localparam int          MODE_TRIG_LSB = 5;

    // core line status bits
    localparam int          CORE_IRQ_BIT  = 0;
    localparam int          CORE_FIQ_BIT  = 1;

    localparam logic [31:0] ARB_SRC_MASK  = 32'hffff_fffe;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;

    typedef enum logic [1:0] {
        TRIG_LEVEL_LOW  = 2'h0,
        TRIG_RISE       = 2'h1,
        TRIG_LEVEL_HIGH = 2'h2,
        TRIG_FALL       = 2'h3
    } trig_t;

    typedef struct packed {
        logic [31:0][31:0] hvec;
        logic [31:0][1:0]  trig;
        logic [31:0][2:0]  prio;
        logic [31:0]       mask;
        logic [31:0]       ffe;
        logic [31:0]       mem;
        logic [31:0]       sync1;
        logic [31:0]       sync2;
        logic [31:0]       lin;
        logic [31:0]       prev;
        logic [7:0][2:0]   stk_lvl;
        logic [7:0][4:0]   stk_src;
        logic [3:0]        sp;
        logic [31:0]       spur;
        logic              gmask;
        logic              ack;
        logic [31:0]       dat;
        logic              normal_request_n_n;
        logic              fast_request_n_n;
        logic              wake;
    } state_t;

endpackage

// *** core/vec_intc.sv ***
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1 - runs on free clock, unaffected by power
// R2 - either request asserts the wake output
// R3 - general mask wakes without normal request
// R4 - source 0 is the fast pin
// R5 - source 1 ORs the system lines
// R6 - sources 2-31 peripheral or external lines
// R7 - per-source trigger type selects condition
// R8 - enable/disable commands build readable mask
// R9 - disabled sources never influence arbitration
// R10 - set/clear commands touch edge memory only
// R11 - vector read clears current source only
// R12 - no auto clear on fast-forced sources
// R13 - fast vector read clears source 0
// R14 - pending shows live activity, unmasked
// R15 - status returns current source number
// R16 - core status mirrors both request lines
// R17 - eight-level arbiter, sources 1-31, unforced
// R18 - priority 7 highest, 0 lowest
// R19 - request asserts early, choice at read
// R20 - ties go to lowest source number
// R21 - in service, only higher level re-requests
// R22 - end-of-service write releases held conditions
// R23 - vector read returns vector, pushes, drops
// R24 - end-of-service pops and may re-request
// R25 - nesting stack holds eight entries
// R26 - source 0 bypasses arbiter, prio stored
// R27 - external pins synchronised, edges remembered
// R28 - two-bit trigger code, internal folds modes

module vec_intc
    import intc_pkg::*;
#(
    parameter int          NSYS     = 4,
    parameter logic [31:0] EXT_MASK = 32'he000_0000
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic [AW-1:0]     ADR_I,
    input  wire logic [31:0]       DAT_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic              WE_I,
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    output logic      [31:0]       DAT_O,
    output logic                   ACK_O,
    input  wire logic              FAST_SOURCE_PIN,
    input  wire logic [NSYS-1:0]   SYSTEM_LINES,
    input  wire logic [31:2]       PERIPHERAL_LINES,
    input  wire logic [31:2]       EXTERNAL_SOURCE_PINS,
    output logic                   NORMAL_REQUEST_N,
    output logic                   FAST_REQUEST_N,
    output logic                   WAKE_REQUEST
);

    state_t        s_q;
    state_t        s_d;

    logic [31:0]   line_now;
    logic [31:0]   is_edge;
    logic [31:0]   hit;
    logic [31:0]   lvl;
    logic [31:0]   active;
    logic [31:0]   cand;
    logic [31:0]   bmask;
    logic [31:0]   wdat;
    logic          take;
    logic          wr;
    logic          rd;
    logic          best_ok;
    logic [4:0]    best_src;
    logic [2:0]    best_lvl;
    logic [2:0]    cur_lvl;
    logic [4:0]    cur_src;
    logic          in_service;
    logic          outrank;
    logic          fiq_now;
    logic [4:0]    ridx;

    ////////////////////////////////////////////////////////////////////////
    // per-source input stage

    generate
        for (genvar i = 0; i < NSRC; i++) begin : g_src
            localparam bit EXT = (i == 0) || EXT_MASK[i];
            if (i == 0) begin : g_fast
                assign line_now[i] = s_q.sync2[i]; // R4
            end else if (i == 1) begin : g_sys
                assign line_now[i] = |SYSTEM_LINES; // R5
            end else if (EXT) begin : g_ext
                assign line_now[i] = s_q.sync2[i]; // R6
            end else begin : g_per
                assign line_now[i] = PERIPHERAL_LINES[i]; // R6
            end
            // odd codes are edge modes for both kinds of source
            assign is_edge[i] = s_q.trig[i][0]; // R28
            if (EXT) begin : g_ext_cond
                assign hit[i] = (s_q.trig[i] == TRIG_RISE)
                              ? (s_q.lin[i] & ~s_q.prev[i])
                              : (~s_q.lin[i] & s_q.prev[i]); // R7
                assign lvl[i] = (s_q.trig[i] == TRIG_LEVEL_HIGH)
                              ? s_q.lin[i] : ~s_q.lin[i]; // R7
            end else begin : g_int_cond
                // polarity of internal lines is fixed high
                assign hit[i] = s_q.lin[i] & ~s_q.prev[i]; // R28
                assign lvl[i] = s_q.lin[i]; // R28
            end
        end
    endgenerate

    assign active = (is_edge & s_q.mem) | (~is_edge & lvl); // R27
    // source 0 and fast-forced sources stay out of the arbiter
    assign cand   = active & s_q.mask & ~s_q.ffe & ARB_SRC_MASK; // R9 R17 R26

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    assign take = CYC_I & STB_I & ~s_q.ack;
    assign wr   = take & WE_I;
    assign rd   = take & ~WE_I;
    assign ridx = ADR_I[6:2];
    assign bmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}},
                    {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    assign wdat = DAT_I & bmask;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;

        // two flops per external pin before any use
        s_d.sync1 = {EXTERNAL_SOURCE_PINS, 1'b0, FAST_SOURCE_PIN}; // R27
        s_d.sync2 = s_q.sync1; // R27
        s_d.lin   = line_now;
        s_d.prev  = s_q.lin;

        // arbiter: ascending scan with strict compare keeps lowest id
        best_ok  = 1'b0;
        best_src = 5'h00;
        best_lvl = 3'h0;
        for (int i = 1; i < NSRC; i++) begin
            if (cand[i] && (!best_ok || s_q.prio[i] > best_lvl)) begin // R18 R20
                best_ok  = 1'b1;
                best_src = 5'(i);
                best_lvl = s_q.prio[i];
            end
        end
        in_service = (s_q.sp != 4'h0);
        cur_lvl    = in_service ? s_q.stk_lvl[3'(s_q.sp - 4'h1)] : 3'h0;
        cur_src    = in_service ? s_q.stk_src[3'(s_q.sp - 4'h1)] : 5'h00;
        // lower or equal levels wait for end of service
        outrank    = best_ok && (!in_service || best_lvl > cur_lvl); // R19 R21 R22
        fiq_now    = |(active & s_q.mask & (s_q.ffe | 32'h0000_0001)); // R26

        // edge memory: detected edges latch
        s_d.mem = s_q.mem | (hit & is_edge); // R27

        s_d.ack = take;
        s_d.dat = RST_WORD;

        if (wr) begin
            unique case (ADR_I)
                OFF_EN:    s_d.mask  = s_q.mask | wdat; // R8
                OFF_DIS:   s_d.mask  = s_q.mask & ~wdat; // R8
                // a fresh edge in the clear cycle keeps the memory set
                OFF_CLR:   s_d.mem   = (s_q.mem & ~(wdat & is_edge))
                                     | (hit & is_edge); // R10 R27
                OFF_SET:   s_d.mem   = s_d.mem | (wdat & is_edge); // R10
                OFF_FFEN:  s_d.ffe   = (s_q.ffe | wdat) & ARB_SRC_MASK;
                OFF_FFDIS: s_d.ffe   = s_q.ffe & ~wdat;
                OFF_GMASK: begin
                    if (SEL_I[0]) begin
                        s_d.gmask = DAT_I[0]; // R3
                    end
                end
                OFF_SPUR:  s_d.spur  = (s_q.spur & ~bmask) | wdat;
                OFF_EOS: begin
                    if (in_service) begin
                        s_d.sp = s_q.sp - 4'h1; // R22 R24
                    end
                end
                default: begin
                    if (ADR_I[8:7] == OFF_MODE[8:7]) begin
                        if (SEL_I[0]) begin
                            s_d.prio[ridx] = DAT_I[MODE_PRIO_LSB +: 3]; // R18
                            s_d.trig[ridx] = DAT_I[MODE_TRIG_LSB +: 2]; // R7
                        end
                    end else if (ADR_I[8:7] == OFF_HVEC[8:7]) begin
                        s_d.hvec[ridx] = (s_q.hvec[ridx] & ~bmask) | wdat;
                    end
                end
            endcase
        end

        if (rd) begin
            unique case (ADR_I)
                OFF_NVEC: begin
                    // a full stack answers spurious rather than wrap
                    if (outrank && s_q.sp != 4'(STK)) begin // R25
                        s_d.dat = s_q.hvec[best_src]; // R23
                        s_d.stk_lvl[s_q.sp[2:0]] = best_lvl; // R23 R25
                        s_d.stk_src[s_q.sp[2:0]] = best_src; // R23 R25
                        s_d.sp  = s_q.sp + 4'h1; // R23
                        // a fresh edge in this cycle still wins
                        if (is_edge[best_src] && !s_q.ffe[best_src]) begin // R12
                            s_d.mem[best_src] = hit[best_src]; // R11
                        end
                    end else begin
                        s_d.dat = s_q.spur;
                    end
                end
                OFF_FVEC: begin
                    s_d.dat = s_q.hvec[0];
                    if (is_edge[0]) begin
                        s_d.mem[0] = hit[0]; // R13
                    end
                end
                OFF_CUR:   s_d.dat = {27'h0, cur_src}; // R15
                OFF_PEND:  s_d.dat = active; // R14
                OFF_MASK:  s_d.dat = s_q.mask; // R8
                OFF_CORE: begin
                    s_d.dat[CORE_IRQ_BIT] = ~s_q.normal_request_n_n; // R16
                    s_d.dat[CORE_FIQ_BIT] = ~s_q.fast_request_n_n; // R16
                end
                OFF_GMASK: s_d.dat = {31'h0, s_q.gmask};
                OFF_SPUR:  s_d.dat = s_q.spur;
                OFF_FFST:  s_d.dat = s_q.ffe;
                default: begin
                    if (ADR_I[8:7] == OFF_MODE[8:7]) begin
                        // source 0 priority reads back, used nowhere
                        s_d.dat[MODE_PRIO_LSB +: 3] = s_q.prio[ridx]; // R26
                        s_d.dat[MODE_TRIG_LSB +: 2] = s_q.trig[ridx];
                    end else if (ADR_I[8:7] == OFF_HVEC[8:7]) begin
                        s_d.dat = s_q.hvec[ridx];
                    end
                end
            endcase
        end

        // the line recomputes from the post-push stack a cycle later
        s_d.normal_request_n_n = ~(outrank & ~s_q.gmask); // R3 R17 R19 R24
        s_d.fast_request_n_n = ~fiq_now; // R4
        s_d.wake   = outrank | fiq_now; // R2 R3
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, never gated

    always_ff @(posedge CLK) begin // R1
        if (RST) begin
            s_q        <= '0;
            s_q.normal_request_n_n <= 1'b1;
            s_q.fast_request_n_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign DAT_O            = s_q.dat;
    assign ACK_O            = s_q.ack;
    assign NORMAL_REQUEST_N = s_q.normal_request_n_n;
    assign FAST_REQUEST_N   = s_q.fast_request_n_n;
    assign WAKE_REQUEST     = s_q.wake;

endmodule // vec_intc
`default_nettype wire

// *** bench/intc_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module intc_asserts
    import intc_pkg::*;
(
    input wire logic          CLK,
    input wire logic          RST,
    input wire logic [AW-1:0] ADR_I,
    input wire logic          WE_I,
    input wire logic          CYC_I,
    input wire logic          STB_I,
    input wire logic [31:0]   DAT_O,
    input wire logic          ACK_O,
    input wire logic          NORMAL_REQUEST_N,
    input wire logic          FAST_REQUEST_N,
    input wire logic          WAKE_REQUEST
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic take;
    assign take = CYC_I && STB_I && !ACK_O;
    sequence nvec_rd;
        take && !WE_I && ADR_I == OFF_NVEC;
    endsequence
    sequence ack_then_drop;
        ##1 ACK_O ##1 NORMAL_REQUEST_N;
    endsequence
    ack_resp_a: assert property (take |=> ACK_O)
        else $error("bus request not acknowledged");
    ack_pulse_a: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    dat_idle_a: assert property (!ACK_O |-> DAT_O == RST_WORD)
        else $error("read data outside ack");
    unmapped_zero_a: assert property
        (take && !WE_I && ADR_I > OFF_FFST |=> DAT_O == RST_WORD)
        else $error("unmapped read not zero");
    core_stat_a: assert property (take && !WE_I && ADR_I == OFF_CORE |=>
        DAT_O[CORE_IRQ_BIT] == !$past(NORMAL_REQUEST_N) &&
        DAT_O[CORE_FIQ_BIT] == !$past(FAST_REQUEST_N))
        else $error("core status not matching lines");
    wake_req_a: assert property
        (!NORMAL_REQUEST_N || !FAST_REQUEST_N |-> WAKE_REQUEST)
        else $error("request without wake");
    nvec_drop_a: assert property (nvec_rd |-> ack_then_drop)
        else $error("normal line not dropped on vector read");
endmodule // intc_asserts
bind vec_intc intc_asserts CHK (
    .CLK(CLK), .RST(RST), .ADR_I(ADR_I), .WE_I(WE_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .NORMAL_REQUEST_N(NORMAL_REQUEST_N), .FAST_REQUEST_N(FAST_REQUEST_N),
    .WAKE_REQUEST(WAKE_REQUEST));
`default_nettype wire

// *** bench/line_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module line_model (
    input  wire logic        CLK,
    input  wire logic [31:0] act,
    output logic             fast_pin = 1'b0,
    output logic [3:0]       system_source = 4'h0,
    output logic [31:2]      per = 30'h0,
    output logic [31:2]      ext = 30'h0
);
    // lines move on the clock edge, as peripheral flops would
    always @(posedge CLK) begin
        fast_pin <= act[0];
        system_source      <= {2'h0, act[1], 1'b0};
        per      <= act[31:2];
        ext      <= act[31:2];
    end
endmodule // line_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import intc_pkg::*;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [8:0]  adr = 9'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, q, act = 32'h0, dat_o;
    logic [3:0]  system_source;
    logic [31:2] per, ext;
    logic        ack, fpin, nrq, frq, wake;
    int          n_errors = 0, tests_run = 0;
    always #5 clk = ~clk;
    line_model PM (.CLK(clk), .act(act), .fast_pin(fpin), .system_source(system_source),
        .per(per), .ext(ext));
    vec_intc DUT (.CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(dat),
        .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_o),
        .ACK_O(ack), .FAST_SOURCE_PIN(fpin), .SYSTEM_LINES(system_source),
        .PERIPHERAL_LINES(per), .EXTERNAL_SOURCE_PINS(ext),
        .NORMAL_REQUEST_N(nrq), .FAST_REQUEST_N(frq), .WAKE_REQUEST(wake));
    ////////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    // request held until ack is seen at a rising edge
    task wb(input logic [8:0] a, input logic w, input logic [31:0] d,
            input logic [3:0] s);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        for (i = 0; i < 9 && ack !== 1'b1; i++) @(posedge clk);
        if (ack !== 1'b1) begin
            n_errors++;
            $display("ERROR %0t ack timeout", $time);
            wrap_up;
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task wr(input logic [8:0] a, input logic [31:0] d);
        wb(a, 1'b1, d, 4'hf);
    endtask
    task rd(input logic [8:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0, 4'hf);
        chk(q, e);
    endtask
    task line(input logic f, input logic e);
        int i;
        for (i = 0; i < 20 && (f ? frq : nrq) !== e; i++) @(posedge clk);
        chk({31'h0, f ? frq : nrq}, {31'h0, e});
    endtask
    // fixed wait covers the longest line latency
    task stay;
        repeat (8) @(posedge clk);
        chk({31'h0, nrq}, 32'h1);
    endtask
    task mode(input int n, input logic [1:0] t, input logic [2:0] p,
              input logic [31:0] v);
        wr(OFF_MODE + 9'(4 * n), {25'h0, t, 2'h0, p});
        wr(OFF_HVEC + 9'(4 * n), v);
        wr(OFF_EN, 32'h1 << n);
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        rd(OFF_MASK, 32'h0);
        rd(OFF_CUR, 32'h0);
        rd(OFF_CORE, 32'h0);
        rd(OFF_PEND, 32'he000_0001);
        // mode write without its low byte lane is dropped
        wb(OFF_MODE + 9'h008, 1'b1, 32'h0000_0027, 4'he);
        rd(OFF_MODE + 9'h008, 32'h0);
        wb(OFF_HVEC + 9'h008, 1'b1, 32'h1122_3344, 4'h3);
        rd(OFF_HVEC + 9'h008, 32'h0000_3344);
        rd(9'h1fc, 32'h0);
        $display("t_reset done");
    endtask
    task t_tie;
        mode(3, TRIG_RISE, 3'h3, 32'h33);
        mode(5, TRIG_RISE, 3'h3, 32'h55);
        wr(OFF_SET, 32'h28);
        line(1'b0, 1'b0);
        rd(OFF_NVEC, 32'h33);
        rd(OFF_CUR, 32'h3);
        rd(OFF_PEND, 32'he000_0021);
        line(1'b0, 1'b1);
        stay;
        wr(OFF_EOS, 32'h0);
        line(1'b0, 1'b0);
        rd(OFF_NVEC, 32'h55);
        wr(OFF_EOS, 32'h0);
        rd(OFF_CUR, 32'h0);
        $display("t_tie done");
    endtask
    task t_nest;
        mode(4, TRIG_RISE, 3'h2, 32'h44);
        act <= 32'h10;
        line(1'b0, 1'b0);
        rd(OFF_NVEC, 32'h44);
        mode(6, TRIG_LEVEL_HIGH, 3'h5, 32'h66);
        act <= 32'h50;
        line(1'b0, 1'b0);
        rd(OFF_NVEC, 32'h66);
        rd(OFF_CUR, 32'h6);
        act <= 32'h10;
        wr(OFF_EOS, 32'h0);
        rd(OFF_CUR, 32'h4);
        wr(OFF_EOS, 32'h0);
        rd(OFF_CUR, 32'h0);
        wr(OFF_SET, 32'h40);
        rd(OFF_PEND, 32'he000_0001);
        $display("t_nest done");
    endtask
    task t_dis;
        wr(OFF_SPUR, 32'hee);
        mode(9, TRIG_RISE, 3'h7, 32'h99);
        wr(OFF_DIS, 32'h200);
        wr(OFF_SET, 32'h200);
        stay;
        rd(OFF_NVEC, 32'hee);
        wr(OFF_CLR, 32'h200);
        rd(OFF_MASK, 32'h78);
        $display("t_dis done");
    endtask
    task t_gmask;
        wr(OFF_GMASK, 32'h1);
        wr(OFF_SET, 32'h8);
        stay;
        chk({31'h0, wake}, 32'h1);
        wr(OFF_CLR, 32'h8);
        wr(OFF_GMASK, 32'h0);
        $display("t_gmask done");
    endtask
    task t_fast;
        mode(0, TRIG_RISE, 3'h0, 32'hf0);
        act <= 32'h11;
        line(1'b1, 1'b0);
        chk({31'h0, wake}, 32'h1);
        rd(OFF_CORE, 32'h2);
        rd(OFF_FVEC, 32'hf0);
        line(1'b1, 1'b1);
        rd(OFF_PEND, 32'he000_0000);
        $display("t_fast done");
    endtask
    task t_sysext;
        mode(1, TRIG_LEVEL_HIGH, 3'h4, 32'h11);
        act <= 32'h13;
        line(1'b0, 1'b0);
        rd(OFF_NVEC, 32'h11);
        act <= 32'h11;
        wr(OFF_EOS, 32'h0);
        // pin goes high first so the falling mode sees no edge
        act <= 32'h4000_0011;
        mode(30, TRIG_FALL, 3'h6, 32'h30);
        stay;
        act <= 32'h11;
        line(1'b0, 1'b0);
        rd(OFF_NVEC, 32'h30);
        wr(OFF_EOS, 32'h0);
        $display("t_sysext done");
    endtask
    task t_force;
        wr(OFF_FFEN, 32'h9);
        rd(OFF_FFST, 32'h8);
        wr(OFF_SET, 32'h8);
        line(1'b1, 1'b0);
        stay;
        rd(OFF_NVEC, 32'hee);
        rd(OFF_FVEC, 32'hf0);
        rd(OFF_PEND, 32'ha000_0008);
        wr(OFF_CLR, 32'h8);
        wr(OFF_FFDIS, 32'h8);
        line(1'b1, 1'b1);
        $display("t_force done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_tie;
        t_nest;
        t_dis;
        t_gmask;
        t_fast;
        t_sysext;
        t_force;
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
